// ---- design/qrb_pkg.sv ----
// Shared widths, timing constants, carriers and states of the burst SRAM port
package qrb_pkg;

  // Array geometry (narrow configuration)
  localparam int DATA_W  = 18;
  localparam int LANE_W  = 9;
  localparam int LANES   = DATA_W / LANE_W;
  localparam int ADDR_W  = 21;
  localparam int BIDX_W  = 2;
  localparam int WADDR_W = ADDR_W + BIDX_W;

  // Burst shape: four words per address
  localparam logic [BIDX_W-1:0] BURST_LAST = 2'h3;
  localparam logic [2:0]        BURST_REST = 3'h3;

  // Read latency in whole link cycles, two data edges per cycle
  localparam int HALF_PER_CYC = 2;
  localparam int LAT_PLL_CYC  = 2;
  localparam int LAT_PLL_OFF_SELECT_CYC = 1;
  localparam logic [2:0] LEAD_PLL  = 3'(LAT_PLL_CYC * HALF_PER_CYC - 1);
  localparam logic [2:0] LEAD_PLL_OFF_SELECT = 3'(LAT_PLL_OFF_SELECT_CYC * HALF_PER_CYC - 1);

  // Depth of the write word buffer
  localparam int WBUF_DEPTH = 2;

  // Link pins after synchronisation
  typedef struct packed {
    logic               k;
    logic               kn;
    logic               rps_n;
    logic               wps_n;
    logic               pll;
    logic [LANES-1:0]   lane_n;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  data;
  } qrb_pins_t;

  // One captured write word on its way to the array
  typedef struct packed {
    logic [WADDR_W-1:0] addr;
    logic [LANES-1:0]   lane_n;
    logic [DATA_W-1:0]  data;
  } qrb_wr_word_t;

  // Write burst sequencer
  typedef enum logic [1:0] {
    QRB_WR_IDLE  = 2'h0,
    QRB_WR_BURST = 2'h1
  } qrb_wr_state_t;

endpackage : qrb_pkg

// ---- design/qrb_buf2.sv ----
// Small valid/ready buffer holding write words ahead of the array
`timescale 1ns/1ns
module qrb_buf2 #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // Filling side
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  // Draining side
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [W-1:0]  store_reg [0:DEPTH-1];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic          push;
  logic          pop;

  ////////////////////////////////////////////////////////////////////////////
  // Honest flags: full stalls the source, empty stalls the sink
  assign o_in_ready  = (count_reg != FULL_CNT);
  assign o_out_valid = (count_reg != '0);
  assign o_out_data  = store_reg[rd_ptr_reg];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // Storage slots carry no reset; the pointers and the count do
  always_ff @(posedge i_clk) begin
    if (push) begin
      store_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  // Pointers wrap at the configured depth
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
      end
    end
  end

  // Occupancy
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      count_reg <= '0;
    end else if (push && !pop) begin
      count_reg <= count_reg + 1'b1;
    end else if (pop && !push) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  chk_buf_no_overrun: assert property (@(posedge i_clk) disable iff (i_rst)
    (count_reg == FULL_CNT && !pop) |=> (count_reg == FULL_CNT))
    else $error("buffer occupancy changed while full");

endmodule : qrb_buf2

// ---- design/qrb_mem_array.sv ----
// Storage array with lane-masked self-timed writes and a word read port
`timescale 1ns/1ns
module qrb_mem_array #(
  parameter int DATA_W = 18,
  parameter int LANE_W = 9,
  parameter int AW     = 23
) (
  // Clock
  input  wire logic                     i_clk,
  // Write side
  input  wire logic                     i_wr_valid,
  output logic                          o_wr_ready,
  input  wire logic [AW-1:0]            i_wr_addr,
  input  wire logic [DATA_W/LANE_W-1:0] i_wr_lane_n,
  input  wire logic [DATA_W-1:0]        i_wr_data,
  // Read side
  input  wire logic                     i_rd_en,
  input  wire logic [AW-1:0]            i_rd_addr,
  output logic [DATA_W-1:0]             o_rd_data
);

  localparam int LANES = DATA_W / LANE_W;

  logic [DATA_W-1:0] mem [0:(2**AW)-1];

  ////////////////////////////////////////////////////////////////////////////
  // One array port: a read fetch takes the cycle and the write waits
  assign o_wr_ready = !i_rd_en;
  assign o_rd_data  = mem[i_rd_addr];

  // Lanes whose select is high keep their old contents
  always_ff @(posedge i_clk) begin
    if (i_wr_valid && o_wr_ready) begin
      for (int g = 0; g < LANES; g++) begin
        if (!i_wr_lane_n[g]) begin
          mem[i_wr_addr][g*LANE_W +: LANE_W] <= i_wr_data[g*LANE_W +: LANE_W];
        end
      end
    end
  end

endmodule : qrb_mem_array

// ---- design/qrb_sram_port.sv ----
// Burst-of-four double-rate SRAM port: pin capture, sequencers, read out
`timescale 1ns/1ns

// How it works
// - Reads leave on their own data lines, writes arrive on separate ones.
// - One address bus; read and write addresses alternate on clock rises.
// - Each address covers four consecutive words moved as one burst.
// - A word moves on every rise of the clock and of its complement.
// - Only rising edges of both input clocks count; falls do nothing.
// - With the PLL pin high, read data starts two cycles after capture.
// - With the PLL pin low, read data starts one cycle after capture.
// - Every synchronous input is registered on a clock or complement rise.
// - Every output word comes from a register updated on those rises.
// - Array writes finish internally; the host only presents words.
// - Read and write ports have independent selects for depth expansion.
// - Echo clocks are driven alongside read data for capture.
// - The valid flag is high while a read word is on the lines.
// - Reads return the newest data, including a same-pair write when the PLL pin is high.
// - Reads and writes proceed concurrently without disturbing each other.
// - Write select low on a clock rise starts a write; high ignores data.
// - Low byte selects gate 9-bit lanes with the data; others stay unaltered.
module qrb_sram_port (
  // System clock and reset
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_sys_rst,
  // Link clocks and controls
  input  wire logic                        i_in_clock,
  input  wire logic                        i_in_clock_n,
  input  wire logic                        i_pll_off_select,
  input  wire logic                        i_read_port_select_n,
  input  wire logic                        i_write_port_select_n,
  input  wire logic [qrb_pkg::ADDR_W-1:0]  i_address,
  // Write port
  input  wire logic [qrb_pkg::LANES-1:0]   i_byte_lane_write_n,
  input  wire logic [qrb_pkg::DATA_W-1:0]  i_write_data,
  output logic                             o_wbuf_ready,
  // Read port
  output logic [qrb_pkg::DATA_W-1:0]       o_read_data,
  output logic                             o_read_valid_flag,
  output logic                             o_echo_clock_out,
  output logic                             o_echo_clock_out_n
);

  qrb_pkg::qrb_pins_t     pins_raw;
  qrb_pkg::qrb_pins_t     pins_s1_reg;
  qrb_pkg::qrb_pins_t     pins_s2_reg;
  logic                   k_prev_reg;
  logic                   kn_prev_reg;
  logic                   k_rise;
  logic                   kn_rise;
  logic                   half_pulse;
  logic                   slot_reg;
  logic                   rd_take;
  logic                   wr_take;
  qrb_pkg::qrb_wr_state_t wr_state_reg;
  logic [1:0]             wr_idx_reg;
  logic [qrb_pkg::ADDR_W-1:0] wr_addr_reg;
  qrb_pkg::qrb_wr_word_t  wr_word;
  logic                   wr_valid;
  qrb_pkg::qrb_wr_word_t  arr_word;
  logic                   arr_valid;
  logic                   arr_ready;
  logic                   pend_valid_reg;
  logic [2:0]             pend_cnt_reg;
  logic [qrb_pkg::ADDR_W-1:0] pend_addr_reg;
  logic [2:0]             burst_left_reg;
  logic [1:0]             burst_idx_reg;
  logic [qrb_pkg::ADDR_W-1:0] burst_addr_reg;
  logic                   rd_start;
  logic                   rd_emit;
  logic [qrb_pkg::WADDR_W-1:0] rd_addr;
  logic [qrb_pkg::DATA_W-1:0]  rd_word;

  ////////////////////////////////////////////////////////////////////////////
  // Pin capture: every pin, clocks included, crosses two flip-flops
  always_comb begin
    pins_raw.k      = i_in_clock;
    pins_raw.kn     = i_in_clock_n;
    pins_raw.rps_n  = i_read_port_select_n;
    pins_raw.wps_n  = i_write_port_select_n;
    pins_raw.pll    = i_pll_off_select;
    pins_raw.lane_n = i_byte_lane_write_n;
    pins_raw.addr   = i_address;
    pins_raw.data   = i_write_data;
  end

  // Selects reset high so nothing starts before the host drives them
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pins_s1_reg <= '{rps_n: 1'b1, wps_n: 1'b1, lane_n: '1, default: '0};
      pins_s2_reg <= '{rps_n: 1'b1, wps_n: 1'b1, lane_n: '1, default: '0};
    end else begin
      pins_s1_reg <= pins_raw;
      pins_s2_reg <= pins_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge finder on the synchronised clocks; falls are never looked at
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      k_prev_reg  <= 1'b0;
      kn_prev_reg <= 1'b0;
    end else begin
      k_prev_reg  <= pins_s2_reg.k;
      kn_prev_reg <= pins_s2_reg.kn;
    end
  end

  assign k_rise     = pins_s2_reg.k && !k_prev_reg;
  assign kn_rise    = pins_s2_reg.kn && !kn_prev_reg;
  assign half_pulse = k_rise || kn_rise;

  // Address slot: first clock rise after reset is a read slot
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      slot_reg <= 1'b0;
    end else if (k_rise) begin
      slot_reg <= !slot_reg;
    end
  end

  // Each port looks only at its own select
  assign rd_take = k_rise && !slot_reg && !pins_s2_reg.rps_n;
  assign wr_take = k_rise && slot_reg && !pins_s2_reg.wps_n;

  ////////////////////////////////////////////////////////////////////////////
  // Write sequencer: word 0 on the select edge, words 1..3 on the next edges
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_state_reg <= qrb_pkg::QRB_WR_IDLE;
      wr_idx_reg   <= '0;
      wr_addr_reg  <= '0;
    end else if (half_pulse) begin
      case (wr_state_reg)
        qrb_pkg::QRB_WR_IDLE: begin
          if (wr_take) begin
            wr_state_reg <= qrb_pkg::QRB_WR_BURST;
            wr_idx_reg   <= 2'h1;
            wr_addr_reg  <= pins_s2_reg.addr;
          end
        end
        qrb_pkg::QRB_WR_BURST: begin
          if (wr_idx_reg == qrb_pkg::BURST_LAST) begin
            wr_state_reg <= qrb_pkg::QRB_WR_IDLE;
            wr_idx_reg   <= '0;
          end else begin
            wr_idx_reg <= wr_idx_reg + 2'h1;
          end
        end
        default: begin
          wr_state_reg <= qrb_pkg::QRB_WR_IDLE;
          wr_idx_reg   <= '0;
        end
      endcase
    end
  end

  // Word with its lane selects, sampled on the same edge as the data
  always_comb begin
    wr_valid = half_pulse &&
               ((wr_state_reg == qrb_pkg::QRB_WR_IDLE && wr_take) ||
                wr_state_reg == qrb_pkg::QRB_WR_BURST);
    wr_word.lane_n = pins_s2_reg.lane_n;
    wr_word.data   = pins_s2_reg.data;
    if (wr_state_reg == qrb_pkg::QRB_WR_BURST) begin
      wr_word.addr = {wr_addr_reg, wr_idx_reg};
    end else begin
      wr_word.addr = {pins_s2_reg.addr, 2'h0};
    end
  end

  // Buffer absorbs the cycles the array spends on read fetches
  qrb_buf2 #(
    .W     ($bits(qrb_pkg::qrb_wr_word_t)),
    .DEPTH (qrb_pkg::WBUF_DEPTH)
  ) u_wbuf (
    .i_clk       (i_ref_clk),
    .i_rst       (i_sys_rst),
    .i_in_valid  (wr_valid),
    .o_in_ready  (o_wbuf_ready),
    .i_in_data   (wr_word),
    .o_out_valid (arr_valid),
    .i_out_ready (arr_ready),
    .o_out_data  (arr_word)
  );

  // Array completes writes on its own once a word is handed over
  qrb_mem_array #(
    .DATA_W (qrb_pkg::DATA_W),
    .LANE_W (qrb_pkg::LANE_W),
    .AW     (qrb_pkg::WADDR_W)
  ) u_array (
    .i_clk       (i_ref_clk),
    .i_wr_valid  (arr_valid),
    .o_wr_ready  (arr_ready),
    .i_wr_addr   (arr_word.addr),
    .i_wr_lane_n (arr_word.lane_n),
    .i_wr_data   (arr_word.data),
    .i_rd_en     (rd_emit),
    .i_rd_addr   (rd_addr),
    .o_rd_data   (rd_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read lead counter: latency is chosen per read by the PLL pin level
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pend_valid_reg <= 1'b0;
      pend_cnt_reg   <= '0;
      pend_addr_reg  <= '0;
    end else if (half_pulse) begin
      if (rd_take) begin
        pend_valid_reg <= 1'b1;
        pend_addr_reg  <= pins_s2_reg.addr;
        pend_cnt_reg   <= pins_s2_reg.pll ? qrb_pkg::LEAD_PLL
                                          : qrb_pkg::LEAD_PLL_OFF_SELECT;
      end else if (pend_valid_reg) begin
        if (pend_cnt_reg == '0) begin
          pend_valid_reg <= 1'b0;
        end else begin
          pend_cnt_reg <= pend_cnt_reg - 3'h1;
        end
      end
    end
  end

  assign rd_start = half_pulse && pend_valid_reg && (pend_cnt_reg == '0);
  assign rd_emit  = rd_start || (half_pulse && burst_left_reg != '0);

  // Words are fetched as they leave, so a write presented on an earlier edge is seen
  assign rd_addr = rd_start ? {pend_addr_reg, 2'h0}
                            : {burst_addr_reg, burst_idx_reg};

  // Burst walker for the remaining three words
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      burst_left_reg <= '0;
      burst_idx_reg  <= '0;
      burst_addr_reg <= '0;
    end else if (rd_start) begin
      burst_left_reg <= qrb_pkg::BURST_REST;
      burst_idx_reg  <= 2'h1;
      burst_addr_reg <= pend_addr_reg;
    end else if (half_pulse && burst_left_reg != '0) begin
      burst_left_reg <= burst_left_reg - 3'h1;
      burst_idx_reg  <= burst_idx_reg + 2'h1;
    end
  end

  // Output register: changes only on a data edge, zero between bursts
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_read_data       <= '0;
      o_read_valid_flag <= 1'b0;
    end else if (half_pulse) begin
      o_read_data       <= rd_emit ? rd_word : '0;
      o_read_valid_flag <= rd_emit;
    end
  end

  // Echo clocks follow the input pair with the same delay as the data
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_echo_clock_out   <= 1'b0;
      o_echo_clock_out_n <= 1'b0;
    end else begin
      o_echo_clock_out   <= pins_s2_reg.k;
      o_echo_clock_out_n <= pins_s2_reg.kn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  chk_slot_alternates: assert property (
    k_rise |=> slot_reg != $past(slot_reg))
    else $error("address slot did not alternate");
  chk_burst_four: assert property (
    rd_start |=> burst_left_reg == 3'h3 && o_read_valid_flag)
    else $error("read burst did not start with three words left");
  chk_rise_only: assert property (
    !half_pulse |=> $stable(o_read_valid_flag) && $stable(wr_state_reg))
    else $error("state moved without a rising clock edge");
  chk_lead_pll: assert property (
    (rd_take && pins_s2_reg.pll) |=> pend_cnt_reg == 3'h3)
    else $error("pll read lead not two cycles");
  chk_lead_pll_off_select: assert property (
    (rd_take && !pins_s2_reg.pll) |=> pend_cnt_reg == 3'h1)
    else $error("pll-off read lead not one cycle");
  chk_data_on_edge: assert property (
    !half_pulse |=> $stable(o_read_data))
    else $error("read data changed between data edges");
  chk_echo_follow: assert property (
    ##1 o_echo_clock_out == $past(pins_s2_reg.k))
    else $error("echo clock does not follow input clock");
  chk_valid_flag: assert property (
    (half_pulse && !rd_emit) |=> !o_read_valid_flag)
    else $error("valid flag high without read data");
  chk_write_desel: assert property (
    (k_rise && slot_reg && pins_s2_reg.wps_n &&
     wr_state_reg == qrb_pkg::QRB_WR_IDLE) |-> !wr_valid)
    else $error("write accepted while port deselected");
  chk_read_select: assert property (
    rd_take |=> pend_valid_reg)
    else $error("read select did not start a read");

endmodule : qrb_sram_port

// ---- sim/qrb_host_model.sv ----
// Host controller model: link clock pair, selects, address, write words
`timescale 1ns/1ns
module qrb_host_model (
  // Clock and reset
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_sys_rst,
  // Device outputs
  input  wire logic [qrb_pkg::DATA_W-1:0] i_read_data,
  input  wire logic                       i_read_valid_flag,
  input  wire logic                       i_echo_clock_out,
  input  wire logic                       i_echo_clock_out_n,
  input  wire logic                       i_wbuf_ready,
  // Link pins
  output logic                            o_in_clock,
  output logic                            o_in_clock_n,
  output logic                            o_pll_off_select,
  output logic                            o_read_port_select_n,
  output logic                            o_write_port_select_n,
  output logic [qrb_pkg::ADDR_W-1:0]      o_address,
  output logic [qrb_pkg::LANES-1:0]       o_byte_lane_write_n,
  output logic [qrb_pkg::DATA_W-1:0]      o_write_data
);
  // One link pair: read slot then write slot
  typedef struct packed {
    logic                         rd_en;
    logic                         pll;
    logic [qrb_pkg::ADDR_W-1:0]   ra;
    logic                         wr_en;
    logic [qrb_pkg::ADDR_W-1:0]   wa;
    logic [4*qrb_pkg::DATA_W-1:0] wd;
    logic [4*qrb_pkg::LANES-1:0]  wl;
  } qrb_pair_t;
  qrb_pair_t                  pq[$];
  qrb_pair_t                  cur;
  qrb_pair_t                  wcur;
  int                         cap_q[$];
  int                         obs_h[$];
  logic [qrb_pkg::DATA_W-1:0] obs_d[$];
  int                         hn, hc, ph, wnum, tail, lead;
  int                         echo_bad, rdy_bad;
  logic                       stopped, fresh, have;

  // Pins start idle with both clocks low
  initial begin
    {o_in_clock, o_in_clock_n} = 2'h0;
    {o_read_port_select_n, o_write_port_select_n, o_pll_off_select} = 3'h7;
    o_address = '0;
    o_write_data = '0;
    o_byte_lane_write_n = '1;
    {echo_bad, rdy_bad, wnum, stopped, fresh} = {32'h0, 32'h0, 32'h4, 2'h3};
  end

  // Pins for the data edge of half n; idle address, data and lane lines toggle, selects stay high
  task automatic prep(input int n);
    {o_read_port_select_n, o_write_port_select_n} = 2'h3;
    o_address = ~o_address;
    if (n % 4 == 0 && pq.size() > 0) begin
      cur = pq.pop_front();
      {have, tail} = {1'b1, 32'd12};
      if (cur.rd_en) cap_q.push_back(n);
      o_read_port_select_n = !cur.rd_en;
      o_pll_off_select = cur.pll;
      o_address = cur.ra;
    end
    if (n % 4 == 2 && have) begin
      {have, wnum, wcur} = {1'b0, 32'h0, cur};
      o_write_port_select_n = !wcur.wr_en;
      o_address = wcur.wa;
    end
    if (wnum < 4) begin
      o_write_data = wcur.wd[wnum*qrb_pkg::DATA_W +: qrb_pkg::DATA_W];
      o_byte_lane_write_n = wcur.wl[wnum*qrb_pkg::LANES +: qrb_pkg::LANES];
      wnum++;
    end else begin
      o_write_data = ~o_write_data;
      o_byte_lane_write_n = ~o_byte_lane_write_n;
    end
  endtask : prep

  ///////////////////////////////////////////////////////////////////////////
  // Half-period sequencer, four reference cycles per data edge; the clock
  // pair stops between frames, so a restart waits for the pins to settle
  always @(posedge i_ref_clk) begin
    #1;
    if (i_sys_rst) begin
      {ph, hn, wnum, tail, lead, have, stopped} = {64'h0, 32'h4, 64'h0, 2'h1};
      {o_in_clock, o_in_clock_n} = 2'h0;
    end else if (stopped) begin
      if (lead > 0) begin
        lead--;
        stopped = (lead > 0);
        fresh = 1'b1;
      end else if (pq.size() > 0) begin
        prep(hn);
        lead = 3;
      end
    end else begin
      if (ph == 0) begin
        o_in_clock   = (hn % 2 == 0);
        o_in_clock_n = (hn % 2 == 1);
        hc = hn;
        hn++;
        tail--;
      end
      if (ph == 2) begin
        // Output of edge hc-1 is settled here
        if (i_read_valid_flag === 1'b1) begin
          obs_h.push_back(hc - 1);
          obs_d.push_back(i_read_data);
        end
        if (!fresh && (i_echo_clock_out !== (hc % 2 == 1) ||
                       i_echo_clock_out_n !== (hc % 2 == 0))) echo_bad++;
        if (i_wbuf_ready !== 1'b1) rdy_bad++;
        fresh = 1'b0;
        prep(hn);
      end
      ph = (ph + 1) % 4;
      if (ph == 0 && hn % 4 == 0 && pq.size() == 0 && wnum == 4 &&
          tail <= 0) begin
        stopped = 1'b1;
        {o_in_clock, o_in_clock_n} = 2'h0;
      end
    end
  end
endmodule : qrb_host_model

// ---- sim/test_qrb_sram_port.sv ----
// Testbench: bursts, latencies, lanes, deselects, concurrency, echo clocks
`timescale 1ns/1ns
module test_qrb_sram_port;
  logic                        ref_clk, sys_rst, k, kn, pll, rsel_n, wsel_n;
  logic                        ready, rvalid, echo, echo_n;
  logic [qrb_pkg::ADDR_W-1:0]  address;
  logic [qrb_pkg::LANES-1:0]   lanes_n;
  logic [qrb_pkg::DATA_W-1:0]  wdata, rdata;
  logic [qrb_pkg::DATA_W-1:0]  mem[logic [qrb_pkg::WADDR_W-1:0]];
  logic [qrb_pkg::DATA_W-1:0]  exp_q[$];
  int                          lat_q[$];
  int                          error_cnt, checks_done;

  qrb_sram_port u_qrb_sram_port (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst),
    .i_in_clock(k), .i_in_clock_n(kn), .i_pll_off_select(pll),
    .i_read_port_select_n(rsel_n), .i_write_port_select_n(wsel_n),
    .i_address(address), .i_byte_lane_write_n(lanes_n),
    .i_write_data(wdata), .o_wbuf_ready(ready), .o_read_data(rdata),
    .o_read_valid_flag(rvalid), .o_echo_clock_out(echo),
    .o_echo_clock_out_n(echo_n));

  qrb_host_model u_qrb_host_model (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst),
    .i_read_data(rdata), .i_read_valid_flag(rvalid),
    .i_echo_clock_out(echo), .i_echo_clock_out_n(echo_n),
    .i_wbuf_ready(ready), .o_in_clock(k), .o_in_clock_n(kn),
    .o_pll_off_select(pll), .o_read_port_select_n(rsel_n),
    .o_write_port_select_n(wsel_n), .o_address(address),
    .o_byte_lane_write_n(lanes_n), .o_write_data(wdata));

  // Reference clock, 20 ns
  always #10 ref_clk = ~ref_clk;

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", what, e, g);
    end
  endtask : chk

  // Queue one link pair and update the shadow memory; the write goes in
  // first, since a same-pair read at long latency fetches it
  task automatic pair(input logic re, input logic [20:0] ra, input logic lp,
                      input logic we, input logic [20:0] wa,
                      input logic [71:0] wd, input logic [7:0] wl);
    u_qrb_host_model.pq.push_back({re, lp, ra, we, wa, wd, wl});
    for (int i = 0; i < 8; i++) begin
      if (we && !wl[i]) mem[{wa, 2'(i / 2)}][(i % 2)*9 +: 9] = wd[i*9 +: 9];
    end
    for (int i = 0; i < 4 && re; i++) exp_q.push_back(mem[{ra, 2'(i)}]);
    if (re) lat_q.push_back(lp ? 4 : 2);
  endtask : pair

  // Distinct word pattern per seed
  function automatic logic [71:0] pat(input logic [7:0] s);
    return {s, 10'h3C4, s, 10'h2D3, s, 10'h1E2, s, 10'h0F1};
  endfunction : pat

  // Run queued pairs, then match every read word to its edge and value
  task automatic drain(input string what);
    int n;
    int h0;
    n = 0;
    while ((u_qrb_host_model.pq.size() > 0 || !u_qrb_host_model.stopped)
           && n < 5000) begin
      @(posedge ref_clk);
      n++;
    end
    chk({what, " settle"}, 0, 32'(n / 5000));
    foreach (lat_q[i]) begin
      h0 = u_qrb_host_model.cap_q.pop_front() + lat_q[i];
      for (int w = 0; w < 4; w++) begin
        if (u_qrb_host_model.obs_h.size() == 0) begin
          chk({what, " missing"}, 0, 1);
          break;
        end
        chk({what, " edge"}, h0 + w, u_qrb_host_model.obs_h.pop_front());
        chk({what, " word"}, exp_q.pop_front(), u_qrb_host_model.obs_d.pop_front());
      end
    end
    chk({what, " extra"}, 0, u_qrb_host_model.obs_h.size());
    lat_q.delete();
    exp_q.delete();
    u_qrb_host_model.obs_h.delete();
    u_qrb_host_model.obs_d.delete();
  endtask : drain

  task automatic t_basic;
    pair(0, 21'h00010, 1, 1, 21'h00010, pat(8'h11), 8'h00);
    pair(1, 21'h00010, 1, 0, 21'h00010, pat(8'h99), 8'h00);
    // PLL pin is static in use: a spare pair lets the long burst finish
    pair(0, 21'h00000, 0, 0, 21'h00000, pat(8'h00), 8'hFF);
    pair(1, 21'h00010, 0, 1, 21'h1FFFF, pat(8'h22), 8'h00);
    pair(0, 21'h1FFFF, 0, 0, 21'h00000, pat(8'h00), 8'hFF);
    pair(1, 21'h1FFFF, 0, 0, 21'h00000, pat(8'h00), 8'hFF);
    drain("basic");
  endtask : t_basic

  task automatic t_lanes;
    pair(0, 21'h00020, 1, 1, 21'h00020, pat(8'h33), 8'h00);
    pair(0, 21'h00020, 1, 1, 21'h00020, pat(8'h44), 8'h1B);
    pair(1, 21'h00020, 1, 0, 21'h00020, pat(8'h55), 8'h00);
    pair(0, 21'h00000, 0, 0, 21'h00000, pat(8'h00), 8'hFF);
    pair(1, 21'h00020, 0, 0, 21'h00020, pat(8'h66), 8'h00);
    drain("lanes");
  endtask : t_lanes

  task automatic t_concurrent;
    pair(1, 21'h00010, 1, 1, 21'h00030, pat(8'h77), 8'h00);
    pair(1, 21'h00030, 1, 1, 21'h00040, pat(8'h88), 8'h00);
    pair(1, 21'h00040, 1, 1, 21'h00040, pat(8'hAA), 8'h00);
    drain("concurrent");
  endtask : t_concurrent

  // Verdict; the only place the run ends
  task automatic tally_and_finish;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial begin
    {ref_clk, sys_rst, error_cnt, checks_done} = {2'h1, 64'h0};
    repeat (8) @(posedge ref_clk);
    chk("valid in reset", 0, rvalid);
    chk("data in reset", 0, rdata);
    chk("echo in reset", 0, {echo, echo_n});
    chk("ready in reset", 1, ready);
    #1 sys_rst = 1'b0;
    t_basic();
    t_lanes();
    t_concurrent();
    chk("echo clocks", 0, u_qrb_host_model.echo_bad);
    chk("buffer ready", 0, u_qrb_host_model.rdy_bad);
    tally_and_finish();
  end

  // Watchdog, far beyond the expected run of a few microseconds
  initial begin
    #400000;
    error_cnt++;
    tally_and_finish();
  end
endmodule : test_qrb_sram_port
